// ==== shared/sfp_pkg.sv ====
`default_nettype none

package sfp_pkg;

    // Clock and lockout timing
    localparam int CLK_HZ = 40_000_000;
    localparam int RD_LOCK_US = 70;
    localparam int PE_LOCK_MS = 3;
    // Least wait, rounded up
    localparam int RD_LOCK_CYC = int'((longint'(RD_LOCK_US) * CLK_HZ + 999_999) / 1_000_000);
    // Longest device delay, rounded down
    localparam int PE_LOCK_CYC = int'((longint'(PE_LOCK_MS) * CLK_HZ) / 1_000);
    // Host side least wait, rounded up
    localparam int PE_WAIT_CYC = int'((longint'(PE_LOCK_MS) * CLK_HZ + 999) / 1_000);
    localparam logic [2:0] SCK_HALF = 3'h4;

    // Command word layout
    localparam int OP_W = 8;
    localparam int PAGE_W = 11;
    localparam int BYTE_W = 9;
    localparam int DUMMY_W = 4;
    localparam int CMD_W = 32;
    localparam int CNT_W = 6;
    localparam int OP_LSB = 24;
    localparam int PAGE_LSB = 9;
    localparam int BYTE_LSB = 0;
    localparam logic [CNT_W-1:0] OP_BITS = 6'h08;
    localparam logic [CNT_W-1:0] CMD_BITS = 6'h20;
    localparam logic [CNT_W-1:0] STAT_BITS = 6'h10;

    // Status byte fields
    localparam int ST_READY = 7;
    localparam int ST_MODE3 = 6;
    localparam int ST_POR = 5;
    localparam logic [7:0] STATUS_RST = 8'h00;

    localparam logic [OP_W-1:0] OP_STATUS = 8'hD7;

    typedef enum logic [1:0] {DS_RESET, DS_WAIT, DS_STANDBY, DS_ACTIVE} sfp_dev_state_t;
    typedef enum logic [2:0] {HS_IDLE, HS_SETUP, HS_SHIFT, HS_END, HS_GAP} sfp_host_state_t;

    function automatic logic sfp_is_pe(input logic [OP_W-1:0] op);
        case (op)
            8'h02, 8'h50, 8'h7C, 8'h81, 8'h82, 8'h83, 8'h85, 8'h86, 8'h88, 8'h89: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : sfp_is_pe

    function automatic logic sfp_is_read(input logic [OP_W-1:0] op);
        case (op)
            8'h03, 8'h0B, 8'h1B, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD6, 8'hD7: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : sfp_is_read

endpackage : sfp_pkg

`default_nettype wire

// ==== shared/sfp_if.sv ====
`timescale 1ns/10ps
`default_nettype none

interface sfp_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic miso_o;
    logic miso_oe_n;
    logic miso;

    // Undriven data line reads as pulled high
    assign miso = miso_oe_n ? 1'b1 : miso_o;

    modport dev (
        input cs_n,
        input sck,
        input mosi,
        output miso_o,
        output miso_oe_n
    );

    modport host (
        output cs_n,
        output sck,
        output mosi,
        input miso
    );
endinterface : sfp_if

`default_nettype wire

// ==== rtl/sfp_sync.sv ====
`timescale 1ns/10ps
`default_nettype none

module sfp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk or posedge rst) begin
        // Reset loads RST_VAL; only u_sys_sync sets it to the idle level of each input, so no false edge follows reset there
        if (rst) begin
            meta_ff <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule : sfp_sync

`default_nettype wire

// ==== rtl/sfp_device.sv ====
`timescale 1ns/10ps
`default_nettype none

module sfp_device #(
    parameter int PE_LOCK_CYC = sfp_pkg::PE_LOCK_CYC
) (
    // System side
    input wire logic clock,
    input wire logic rst,
    input wire logic por,
    // Link
    sfp_if.dev link,
    // Decoded commands
    output logic cmd_valid,
    output logic [sfp_pkg::OP_W-1:0] cmd_op,
    output logic [sfp_pkg::PAGE_W-1:0] cmd_page,
    output logic [sfp_pkg::BYTE_W-1:0] cmd_byte,
    output logic cmd_dropped,
    // Status
    output sfp_pkg::sfp_dev_state_t dev_state,
    output logic pe_ready,
    output logic spi_mode3
);
    import sfp_pkg::*;

    localparam int LW = $clog2(PE_LOCK_CYC + 1);
    localparam logic [LW-1:0] LOCK_LAST = LW'(PE_LOCK_CYC - 1);

    logic frame_rst;
    logic mode3_ff;
    logic [CNT_W-1:0] bit_cnt_ff;
    logic [CMD_W-1:0] rx_ff;
    logic [CMD_W-1:0] rx_next;
    logic stat_rd_ff;
    logic [CMD_W-1:0] cmd_word_ff;
    logic cmd_tgl_ff;
    logic [1:0] stat_s;
    logic [7:0] status_byte;
    logic tx_act_ff;
    logic [7:0] tx_sr_ff;

    logic cs_s;
    logic por_s;
    logic tgl_s;
    logic tgl_d_ff;
    logic new_cmd;
    logic [LW-1:0] lock_cnt_ff;
    logic pe_done_ff;
    logic lock_end;
    sfp_dev_state_t state_ff;
    logic [CMD_W-1:0] out_word_ff;
    logic cmd_valid_ff;
    logic drop_ff;
    logic pend_ff;

    // Deselect clears the whole frame, even with the serial clock stopped
    // abandon on deselect
    assign frame_rst = rst | link.cs_n;

    always_ff @(negedge link.cs_n or posedge rst) begin
        if (rst) begin
            mode3_ff <= 1'b0;
        end else begin
            mode3_ff <= link.sck;
        end
    end

    assign rx_next = {rx_ff[CMD_W-2:0], link.mosi};

    always_ff @(posedge link.sck or posedge frame_rst) begin
        if (frame_rst) begin
            bit_cnt_ff <= '0;
            rx_ff <= '0;
            stat_rd_ff <= 1'b0;
        end else begin
            rx_ff <= rx_next;
            if (bit_cnt_ff != CMD_BITS) begin
                bit_cnt_ff <= bit_cnt_ff + 6'h01;
            end
            if (bit_cnt_ff == OP_BITS - 6'h01 && rx_next[OP_W-1:0] == OP_STATUS) begin
                stat_rd_ff <= 1'b1;
            end
        end
    end

    // Word is held until the next full frame, so the system side reads it stable
    // only complete words
    always_ff @(posedge link.sck or posedge rst) begin
        if (rst) begin
            cmd_word_ff <= '0;
            cmd_tgl_ff <= 1'b0;
        end else if (!link.cs_n && !stat_rd_ff && bit_cnt_ff == CMD_BITS - 6'h01) begin
            cmd_word_ff <= rx_next;
            cmd_tgl_ff <= ~cmd_tgl_ff;
        end
    end

    sfp_sync #(.W(2)) u_stat_sync (
        .clk(link.sck),
        .rst(rst),
        .d({pe_done_ff, por}),
        .q(stat_s)
    );

    always_comb begin
        status_byte = STATUS_RST;
        status_byte[ST_READY] = stat_s[1];
        status_byte[ST_MODE3] = mode3_ff;
        status_byte[ST_POR] = stat_s[0];
    end

    // Mode 3 leading fall arrives before any opcode bit, so it never loads
    // drive only on status read
    always_ff @(negedge link.sck or posedge frame_rst) begin
        if (frame_rst) begin
            tx_act_ff <= 1'b0;
            tx_sr_ff <= STATUS_RST;
        end else if (stat_rd_ff) begin
            if (!tx_act_ff) begin
                tx_act_ff <= 1'b1;
                tx_sr_ff <= status_byte;
            end else begin
                tx_sr_ff <= {tx_sr_ff[6:0], tx_sr_ff[7]};
            end
        end
    end

    assign link.miso_o = tx_sr_ff[7];
    assign link.miso_oe_n = ~tx_act_ff;

    // Reads as deselected and held in power-on reset until real samples arrive
    sfp_sync #(.W(3), .RST_VAL(3'h6)) u_sys_sync (
        .clk(clock),
        .rst(rst),
        .d({link.cs_n, por, cmd_tgl_ff}),
        .q({cs_s, por_s, tgl_s})
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tgl_d_ff <= 1'b0;
        end else begin
            tgl_d_ff <= tgl_s;
        end
    end

    assign new_cmd = tgl_s ^ tgl_d_ff;
    assign lock_end = !pe_done_ff && lock_cnt_ff == LOCK_LAST;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lock_cnt_ff <= '0;
            pe_done_ff <= 1'b0;
        end else if (por_s) begin
            lock_cnt_ff <= '0;
            pe_done_ff <= 1'b0;
        end else if (lock_end) begin
            pe_done_ff <= 1'b1;
        end else if (!pe_done_ff) begin
            lock_cnt_ff <= lock_cnt_ff + LW'(1);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= DS_RESET;
        end else if (por_s) begin
            state_ff <= DS_RESET;
        end else begin
            case (state_ff)
                DS_RESET: begin
                    state_ff <= DS_WAIT;
                end
                DS_WAIT: begin
                    if (lock_end) begin
                        state_ff <= cs_s ? DS_STANDBY : DS_ACTIVE;
                    end
                end
                DS_STANDBY: begin
                    if (!cs_s) begin
                        state_ff <= DS_ACTIVE;
                    end
                end
                DS_ACTIVE: begin
                    if (cs_s) begin
                        state_ff <= DS_STANDBY;
                    end
                end
                default: begin
                    state_ff <= DS_RESET;
                end
            endcase
        end
    end

    // Early program or erase is held until the delay runs out; a word in power-on reset or behind a held one is dropped
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            out_word_ff <= '0;
            cmd_valid_ff <= 1'b0;
            drop_ff <= 1'b0;
            pend_ff <= 1'b0;
        end else begin
            cmd_valid_ff <= 1'b0;
            drop_ff <= 1'b0;
            if (por_s) begin
                pend_ff <= 1'b0;
                drop_ff <= new_cmd;
            end else if (new_cmd && !pend_ff) begin
                out_word_ff <= cmd_word_ff;
                if (sfp_is_pe(cmd_word_ff[OP_LSB +: OP_W]) && !pe_done_ff) begin
                    pend_ff <= 1'b1;
                end else begin
                    cmd_valid_ff <= 1'b1;
                end
            end else if (new_cmd) begin
                drop_ff <= 1'b1;
            end else if (pend_ff && pe_done_ff) begin
                pend_ff <= 1'b0;
                cmd_valid_ff <= 1'b1;
            end
        end
    end

    assign cmd_valid = cmd_valid_ff;
    assign cmd_dropped = drop_ff;
    assign cmd_op = out_word_ff[OP_LSB +: OP_W];
    assign cmd_page = out_word_ff[PAGE_LSB +: PAGE_W];
    assign cmd_byte = out_word_ff[BYTE_LSB +: BYTE_W];
    assign dev_state = state_ff;
    assign pe_ready = pe_done_ff;
    assign spi_mode3 = mode3_ff;
endmodule : sfp_device

`default_nettype wire

// ==== rtl/sfp_host.sv ====
`timescale 1ns/10ps
`default_nettype none

module sfp_host #(
    parameter int PE_WAIT_CYC = sfp_pkg::PE_WAIT_CYC
) (
    // System side
    input wire logic clock,
    input wire logic rst,
    input wire logic power_good,
    // Request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [sfp_pkg::OP_W-1:0] req_op,
    input wire logic [sfp_pkg::PAGE_W-1:0] req_page,
    input wire logic [sfp_pkg::BYTE_W-1:0] req_byte,
    input wire logic req_mode3,
    // Answer
    output logic rsp_valid,
    output logic [7:0] rsp_status,
    // Lockout
    output logic read_ok,
    output logic pe_ok,
    // Link
    sfp_if.host link
);
    import sfp_pkg::*;

    // Counter must reach the longer of the two waits
    localparam int WAIT_MAX = PE_WAIT_CYC > RD_LOCK_CYC ? PE_WAIT_CYC : RD_LOCK_CYC;
    localparam int WW = $clog2(WAIT_MAX + 1);

    logic pg_s;
    logic miso_s;
    logic [WW-1:0] wait_cnt_ff;
    logic read_ok_ff;
    logic pe_ok_ff;
    logic allowed;
    sfp_host_state_t state_ff;
    logic [2:0] ph_ff;
    logic half_end;
    logic cs_n_ff;
    logic sck_ff;
    logic mosi_ff;
    logic mode3_ff;
    logic [CMD_W-1:0] sh_ff;
    logic [CNT_W-1:0] bit_ff;
    logic [CNT_W-1:0] len_ff;
    logic [7:0] rx_ff;
    logic rsp_valid_ff;
    logic [7:0] rsp_ff;

    sfp_sync #(.W(2)) u_sync (
        .clk(clock),
        .rst(rst),
        .d({power_good, link.miso}),
        .q({pg_s, miso_s})
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wait_cnt_ff <= '0;
            read_ok_ff <= 1'b0;
            pe_ok_ff <= 1'b0;
        end else if (!pg_s) begin
            wait_cnt_ff <= '0;
            read_ok_ff <= 1'b0;
            pe_ok_ff <= 1'b0;
        end else begin
            if (wait_cnt_ff != WW'(WAIT_MAX)) begin
                wait_cnt_ff <= wait_cnt_ff + WW'(1);
            end
            read_ok_ff <= wait_cnt_ff >= WW'(RD_LOCK_CYC);
            pe_ok_ff <= wait_cnt_ff >= WW'(PE_WAIT_CYC);
        end
    end

    assign allowed = sfp_is_pe(req_op) ? pe_ok_ff : (sfp_is_read(req_op) ? read_ok_ff : pg_s);
    assign req_ready = state_ff == HS_IDLE && allowed;
    assign half_end = ph_ff == SCK_HALF - 3'h1;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= HS_IDLE;
            ph_ff <= '0;
            cs_n_ff <= 1'b1;
            sck_ff <= 1'b0;
            mosi_ff <= 1'b0;
            mode3_ff <= 1'b0;
            sh_ff <= '0;
            bit_ff <= '0;
            len_ff <= '0;
            rx_ff <= STATUS_RST;
            rsp_valid_ff <= 1'b0;
            rsp_ff <= STATUS_RST;
        end else begin
            rsp_valid_ff <= 1'b0;
            ph_ff <= half_end ? 3'h0 : ph_ff + 3'h1;
            case (state_ff)
                HS_IDLE: begin
                    ph_ff <= '0;
                    if (req_valid && allowed) begin
                        sh_ff <= {req_op, {DUMMY_W{1'b0}}, req_page, req_byte};
                        len_ff <= req_op == OP_STATUS ? STAT_BITS : CMD_BITS;
                        mode3_ff <= req_mode3;
                        sck_ff <= req_mode3;
                        bit_ff <= '0;
                        state_ff <= HS_SETUP;
                    end
                end
                HS_SETUP: begin
                    if (half_end) begin
                        cs_n_ff <= 1'b0;
                        mosi_ff <= sh_ff[CMD_W-1];
                        state_ff <= HS_SHIFT;
                    end
                end
                HS_SHIFT: begin
                    if (half_end) begin
                        sck_ff <= ~sck_ff;
                        if (sck_ff && bit_ff != '0) begin
                            sh_ff <= {sh_ff[CMD_W-2:0], 1'b0};
                            mosi_ff <= sh_ff[CMD_W-2];
                        end
                        if (!sck_ff) begin
                            rx_ff <= {rx_ff[6:0], miso_s};
                            bit_ff <= bit_ff + 6'h01;
                            if (bit_ff == len_ff - 6'h01) begin
                                state_ff <= HS_END;
                            end
                        end
                    end
                end
                HS_END: begin
                    if (half_end) begin
                        sck_ff <= mode3_ff;
                        state_ff <= HS_GAP;
                    end
                end
                HS_GAP: begin
                    if (half_end) begin
                        cs_n_ff <= 1'b1;
                        rsp_ff <= rx_ff;
                        rsp_valid_ff <= len_ff == STAT_BITS;
                        state_ff <= HS_IDLE;
                    end
                end
                default: begin
                    state_ff <= HS_IDLE;
                end
            endcase
        end
    end

    assign link.cs_n = cs_n_ff;
    assign link.sck = sck_ff;
    assign link.mosi = mosi_ff;
    assign rsp_valid = rsp_valid_ff;
    assign rsp_status = rsp_ff;
    assign read_ok = read_ok_ff;
    assign pe_ok = pe_ok_ff;
endmodule : sfp_host

`default_nettype wire

// ==== verif/sfp_checker.sv ====
`timescale 1ns/10ps
`default_nettype none

module sfp_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Link
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso_oe_n
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // Clock rises since select; saturates so a long frame cannot wrap
    logic [5:0] rise_cnt_ff;
    logic sck_q_ff;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sck_q_ff <= 1'b0;
        end else begin
            sck_q_ff <= sck;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rise_cnt_ff <= 6'h00;
        end else if (cs_n) begin
            rise_cnt_ff <= 6'h00;
        end else if (sck && !sck_q_ff && rise_cnt_ff != 6'h3F) begin
            rise_cnt_ff <= rise_cnt_ff + 6'h01;
        end
    end

    float_deselect_a: assert property (cs_n |-> miso_oe_n)
        else $error("data out driven while deselected");
    drive_after_op_a: assert property ($fell(miso_oe_n) |-> rise_cnt_ff == 6'h08 && !sck)
        else $error("data out driven before opcode complete");
    mode_clock_hold_a: assert property ($fell(cs_n) |-> $stable(sck)[*4] ##1 $changed(sck))
        else $error("clock idle level not held at select");
    sck_half_period_a: assert property (!cs_n && $changed(sck) |=> $stable(sck)[*3])
        else $error("clock half period too short");
    select_gap_a: assert property ($rose(cs_n) |=> cs_n[*3])
        else $error("deselect gap too short");
    deselect_still_a: assert property ($rose(cs_n) |-> $stable(sck)[*2])
        else $error("clock moved at deselect");
    data_at_rise_a: assert property (!cs_n && $rose(sck) |-> $stable(mosi))
        else $error("data changed at sampling edge");
    whole_frame_a: assert property ($rose(cs_n) |-> rise_cnt_ff == 6'h20 || rise_cnt_ff == 6'h10)
        else $error("frame not whole");

    cover property ($fell(cs_n) && sck);
    cover property ($fell(cs_n) && !sck);
    cover property ($fell(miso_oe_n));
endmodule : sfp_checker

`default_nettype wire

// ==== verif/serial_flash_powerup_front_end_tb.sv ====
`timescale 1ns/10ps
`default_nettype none

module serial_flash_powerup_front_end_tb;
    import sfp_pkg::*;

    // Short device delay so an early frame outlasts part of it
    localparam int DEV_LOCK = 400;
    localparam int HOST_WAIT = 60;

    logic clock = 1'b0;
    logic rst = 1'b1;
    logic por = 1'b1;
    logic power_good = 1'b0;
    // Host alone can be reset to cut a frame short
    logic cut = 1'b0;
    logic host_rst;
    logic req_valid = 1'b0;
    logic [OP_W-1:0] req_op = 8'h00;
    logic [PAGE_W-1:0] req_page = 11'h000;
    logic [BYTE_W-1:0] req_byte = 9'h000;
    logic req_mode3 = 1'b0;
    logic req_ready, rsp_valid, read_ok, pe_ok;
    logic [7:0] rsp_status;
    logic cmd_valid, cmd_dropped, pe_ready, spi_mode3;
    logic [OP_W-1:0] cmd_op;
    logic [PAGE_W-1:0] cmd_page;
    logic [BYTE_W-1:0] cmd_byte;
    sfp_dev_state_t dev_state;
    int n_errors = 0;
    int checked = 0;
    int cmd_cnt_ff = 0;
    int drop_cnt_ff = 0;
    logic [7:0] status_ff = 8'h00;
    logic rdy_at_cmd_ff = 1'b0;
    logic rdy_q_ff = 1'b0;
    logic rdy_q2_ff = 1'b0;
    sfp_dev_state_t end_state_ff = DS_RESET;

    sfp_if link_if();

    assign host_rst = rst | cut;

    sfp_device #(.PE_LOCK_CYC(DEV_LOCK)) sfp_device_inst (.clock(clock), .rst(rst), .por(por),
        .link(link_if.dev), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_page(cmd_page),
        .cmd_byte(cmd_byte), .cmd_dropped(cmd_dropped), .dev_state(dev_state),
        .pe_ready(pe_ready), .spi_mode3(spi_mode3));

    sfp_host #(.PE_WAIT_CYC(HOST_WAIT)) sfp_host_inst (.clock(clock), .rst(host_rst),
        .power_good(power_good), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
        .req_page(req_page), .req_byte(req_byte), .req_mode3(req_mode3),
        .rsp_valid(rsp_valid), .rsp_status(rsp_status), .read_ok(read_ok), .pe_ok(pe_ok),
        .link(link_if.host));

    sfp_checker sfp_checker_inst (.clock(clock), .rst(host_rst), .cs_n(link_if.cs_n),
        .sck(link_if.sck), .mosi(link_if.mosi), .miso_oe_n(link_if.miso_oe_n));

    always #12.5 clock = ~clock;

    // Event monitor; state is captured two cycles after the delay ends
    always @(posedge clock) begin
        rdy_q_ff <= pe_ready;
        rdy_q2_ff <= rdy_q_ff;
        if (rdy_q_ff === 1'b1 && rdy_q2_ff === 1'b0) begin
            end_state_ff <= dev_state;
        end
        if (cmd_valid === 1'b1) begin
            cmd_cnt_ff <= cmd_cnt_ff + 1;
            rdy_at_cmd_ff <= pe_ready;
        end
        if (cmd_dropped === 1'b1) begin
            drop_cnt_ff <= drop_cnt_ff + 1;
        end
        if (rsp_valid === 1'b1) begin
            status_ff <= rsp_status;
        end
    end

    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("Compared %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    // Bounded wait: 0 pe_ok, 1 pe_ready, 2 read_ok, 3 req_ready
    task automatic wait_for(input int sel, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(negedge clock);
            if ((sel == 0 && pe_ok === 1'b1) || (sel == 1 && pe_ready === 1'b1) ||
                (sel == 2 && read_ok === 1'b1) || (sel == 3 && req_ready === 1'b1)) begin
                break;
            end
        end
        if (i == lim) begin
            n_errors++;
            $display("[FAIL] %0t wait ran out", $time);
            conclude();
        end
    endtask : wait_for

    // One whole request, held until taken, then wait for idle
    task automatic send(input logic [7:0] op, input logic [10:0] page, input logic [8:0] byt,
                        input logic mode3);
        @(posedge clock);
        req_valid <= 1'b1;
        req_op <= op;
        req_page <= page;
        req_byte <= byt;
        req_mode3 <= mode3;
        wait_for(3, 50);
        @(posedge clock);
        req_valid <= 1'b0;
        wait_for(3, 400);
        repeat (8) @(negedge clock);
    endtask : send

    task automatic refuse(input logic [7:0] op);
        @(posedge clock);
        req_valid <= 1'b1;
        req_op <= op;
        repeat (12) @(negedge clock);
        check(11'(req_ready), 11'h000);
        check(11'(link_if.cs_n), 11'h001);
        @(posedge clock);
        req_valid <= 1'b0;
    endtask : refuse

    initial begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        check(11'(link_if.miso_oe_n), 11'h001);
        check(11'(dev_state), 11'(DS_RESET));
        @(posedge clock);
        power_good <= 1'b1;
        refuse(8'h03);
        refuse(8'h82);
        check(11'(pe_ok), 11'h000);
        send(8'h84, 11'h000, 9'h0AB, 1'b0);
        check(11'(drop_cnt_ff), 11'h001);
        check(11'(cmd_cnt_ff), 11'h000);
        wait_for(0, 200);
        check(11'(pe_ok), 11'h001);
        check(11'(read_ok), 11'h000);
        @(posedge clock);
        por <= 1'b0;
        send(8'h82, 11'h5A5, 9'h1C3, 1'b0);
        check(11'(cmd_cnt_ff), 11'h000);
        check(11'(dev_state), 11'(DS_WAIT));
        wait_for(1, DEV_LOCK + 20);
        repeat (8) @(negedge clock);
        check(11'(cmd_cnt_ff), 11'h001);
        check(11'(rdy_at_cmd_ff), 11'h001);
        check(11'(cmd_op), 11'h082);
        check(cmd_page, 11'h5A5);
        check(11'(cmd_byte), 11'h1C3);
        check(11'(end_state_ff), 11'(DS_STANDBY));
        wait_for(2, 3000);
        send(OP_STATUS, 11'h000, 9'h000, 1'b1);
        check(11'(status_ff), 11'((1 << ST_READY) | (1 << ST_MODE3)));
        check(11'(spi_mode3), 11'h001);
        send(OP_STATUS, 11'h000, 9'h000, 1'b0);
        check(11'(status_ff), 11'(1 << ST_READY));
        check(11'(link_if.miso_oe_n), 11'h001);
        @(posedge clock);
        por <= 1'b1;
        repeat (6) @(negedge clock);
        check(11'(dev_state), 11'(DS_RESET));
        check(11'(pe_ready), 11'h000);
        @(posedge clock);
        por <= 1'b0;
        // Start late enough that the delay ends mid-frame
        repeat (330) @(posedge clock);
        send(8'h84, 11'h3FF, 9'h1FF, 1'b0);
        check(11'(end_state_ff), 11'(DS_ACTIVE));
        check(11'(dev_state), 11'(DS_STANDBY));
        check(cmd_page, 11'h3FF);
        // Reset the host in mid-frame; the device must discard the partial word without flagging it as dropped
        @(posedge clock);
        req_valid <= 1'b1;
        req_op <= 8'h87;
        req_page <= 11'h2AA;
        repeat (2) @(posedge clock);
        req_valid <= 1'b0;
        repeat (100) @(posedge clock);
        cut <= 1'b1;
        repeat (2) @(posedge clock);
        cut <= 1'b0;
        repeat (8) @(negedge clock);
        check(11'(cmd_cnt_ff), 11'h002);
        check(11'(drop_cnt_ff), 11'h001);
        send(8'h84, 11'h0F0, 9'h00F, 1'b0);
        check(11'(cmd_cnt_ff), 11'h003);
        check(cmd_page, 11'h0F0);
        check(11'(cmd_byte), 11'h00F);
        conclude();
    end
endmodule : serial_flash_powerup_front_end_tb

`default_nettype wire
